// [core/stack_unit_map.vh]
// constants for the stack push/pop unit
`ifndef STACK_UNIT_MAP_VH
`define STACK_UNIT_MAP_VH
// operation codes
`define OP_IDLE        3'h0
`define OP_PUSH_SEL    3'h1
`define OP_POP_SEL     3'h2
`define OP_PUSH_ERR    3'h3
`define OP_POP_MEM     3'h4
`define OP_FAR_CALL    3'h5
// fault codes
`define FLT_NONE       3'h0
`define FLT_STACK      3'h1
`define FLT_BRANCH     3'h2
`define FLT_MEM        3'h3
// wrap start points, wrap target and 64K limit of a 16-bit stack
`define WRAP_SP_32     32'h0000fffc
`define WRAP_SP_16     32'h0000fffe
`define WRAP_TARGET_HI 32'h00010000
`define SEG64K_LIMIT   32'h0000ffff
// byte enables
`define BE_LOW2        4'h3
`define BE_ALL4        4'hf
`endif

// [core/stack_addr_calc.v]
// stack pointer step and effective address for one access
`timescale 1ns/1ps
module stack_addr_calc #(
  parameter WIDTH = 32
) (
  input  wire [WIDTH-1:0] sp_in,
  input  wire             op32_in,
  input  wire             stack32_in,
  input  wire             dec_in,
  output wire [WIDTH-1:0] sp_new_out,
  output wire             wrap_out
);
  wire [WIDTH-1:0] step;
  wire [WIDTH-1:0] raw;
  assign step = op32_in ? {{(WIDTH-3){1'b0}}, 3'h4} :
                          {{(WIDTH-3){1'b0}}, 3'h2};
  assign raw  = dec_in ? sp_in - step : sp_in + step;
  // a 16-bit stack keeps the upper half of the pointer
  assign sp_new_out = stack32_in ? raw : {sp_in[WIDTH-1:16], raw[15:0]};
  assign wrap_out   = ~stack32_in & ~dec_in & (raw[15:0] < sp_in[15:0]);
endmodule // stack_addr_calc

// [core/stack_push_pop_unit.v]
// stack push/pop sequencer facing the stack memory
`timescale 1ns/1ps
`include "stack_unit_map.vh"
module stack_push_pop_unit #(
  parameter SIZED_SEL = 0
) (
  input  wire        core_clk_in,
  input  wire        sys_rst_in,
  input  wire        req_valid_in,
  input  wire [2:0]  req_op_in,
  input  wire        op32_in,
  input  wire        stack32_in,
  input  wire        real_mode_in,
  input  wire [31:0] seg_limit_in,
  input  wire [31:0] sp_init_in,
  input  wire [31:0] wdata_in,
  input  wire [31:0] index_disp_in,
  input  wire [15:0] call_cs_in,
  input  wire [31:0] call_ip_in,
  input  wire        branch_limit_err_in,
  input  wire        branch_rights_err_in,
  input  wire        mem_ready_in,
  input  wire        mem_err_in,
  input  wire [31:0] mem_rdata_in,
  output reg         busy_out,
  output reg         done_out,
  output reg  [2:0]  fault_out,
  output reg  [31:0] stack_pointer_out,
  output reg  [31:0] rdata_out,
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [31:0] mem_addr_out,
  output reg  [3:0]  mem_be_out,
  output reg  [31:0] mem_wdata_out
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_MEM   = 3'h1;
  localparam ST_PUSH2 = 3'h2;
  localparam ST_POPWR = 3'h3;
  localparam ST_DONE  = 3'h4;

  reg  [2:0]  state_r;
  reg  [2:0]  op_r;
  reg         op32_r;
  reg         stack32_r;
  reg  [31:0] sp_saved_r;
  reg  [31:0] ip_r;
  reg  [31:0] idx_r;
  reg  [31:0] data_r;
  wire [31:0] sp_dec;
  wire [31:0] sp_inc;
  wire        wrap;
  wire        is_pop;
  wire        wide_acc;
  wire [31:0] last_byte;
  wire        limit_hi_bad;
  wire        wrap_start;
  reg         ip_phase_r;
  reg  [31:0] acc_addr_nxt;
  reg  [3:0]  acc_be_nxt;
  reg  [31:0] acc_wdata_nxt;
  reg  [31:0] popwr_base_nxt;
  reg  [31:0] popwr_addr_nxt;
  reg         wrap_fault_nxt;
  reg  [31:0] pop_val_nxt;
  reg  [2:0]  after_acc_nxt;

  stack_addr_calc #(.WIDTH(32)) u_dec (
    .sp_in      (stack_pointer_out),
    .op32_in    (op32_r),
    .stack32_in (stack32_r),
    .dec_in     (1'b1),
    .sp_new_out (sp_dec),
    .wrap_out   ()
  );
  stack_addr_calc #(.WIDTH(32)) u_inc (
    .sp_in      (stack_pointer_out),
    .op32_in    (op32_r),
    .stack32_in (stack32_r),
    .dec_in     (1'b0),
    .sp_new_out (sp_inc),
    .wrap_out   (wrap)
  );

  assign is_pop   = (op_r == `OP_POP_SEL) | (op_r == `OP_POP_MEM);
  // wide access: error codes always, selectors only in the sized variant
  assign wide_acc = (op_r == `OP_PUSH_ERR) | (op_r == `OP_FAR_CALL & op32_r)
                  | (op_r == `OP_POP_MEM & op32_r)
                  | ((SIZED_SEL != 0) & op32_r);
  assign last_byte = (is_pop ? stack_pointer_out : sp_dec) + 32'h3;
  assign limit_hi_bad = wide_acc & (op_r == `OP_PUSH_SEL | op_r == `OP_POP_SEL)
                      & (last_byte > seg_limit_in);

  // access shape of the next stack memory cycle
  always @* begin
    acc_addr_nxt  = sp_dec;
    acc_be_nxt    = `BE_LOW2;
    acc_wdata_nxt = data_r;
    case (op_r)
      `OP_PUSH_SEL: begin
        acc_addr_nxt  = sp_dec;
        acc_be_nxt    = wide_acc ? `BE_ALL4 : `BE_LOW2;
        acc_wdata_nxt = {16'h0, data_r[15:0]};
      end
      `OP_POP_SEL: begin
        acc_addr_nxt  = stack_pointer_out;
        acc_be_nxt    = wide_acc ? `BE_ALL4 : `BE_LOW2;
        acc_wdata_nxt = 32'h0;
      end
      `OP_PUSH_ERR: begin
        acc_addr_nxt  = sp_dec;
        acc_be_nxt    = `BE_ALL4;
        acc_wdata_nxt = {16'h0, data_r[15:0]};
      end
      `OP_POP_MEM: begin
        acc_addr_nxt  = stack_pointer_out;
        acc_be_nxt    = op32_r ? `BE_ALL4 : `BE_LOW2;
        acc_wdata_nxt = 32'h0;
      end
      `OP_FAR_CALL: begin
        acc_addr_nxt  = sp_dec;
        acc_be_nxt    = op32_r ? `BE_ALL4 : `BE_LOW2;
        acc_wdata_nxt = data_r;
      end
      default: begin
        acc_addr_nxt  = sp_dec;
        acc_be_nxt    = `BE_LOW2;
        acc_wdata_nxt = data_r;
      end
    endcase
  end

  // popped value width follows the access
  always @* begin
    pop_val_nxt = {16'h0, mem_rdata_in[15:0]};
    if (wide_acc)
      pop_val_nxt = mem_rdata_in;
  end

  // where a finished memory cycle leads
  always @* begin
    case (op_r)
      `OP_POP_MEM:  after_acc_nxt = ST_POPWR;
      `OP_FAR_CALL: after_acc_nxt = ip_phase_r ? ST_DONE : ST_PUSH2;
      default:      after_acc_nxt = ST_DONE;
    endcase
  end

  // wrap writes offset zero plus index
  // or offset 10000h in the sized variant
  assign wrap_start = ~stack32_r &
                      ({16'h0, sp_saved_r[15:0]} ==
                       (op32_r ? `WRAP_SP_32 : `WRAP_SP_16));
  always @* begin
    popwr_base_nxt = stack32_r ? stack_pointer_out :
                     {16'h0, stack_pointer_out[15:0]};
    if ((SIZED_SEL != 0) && wrap_start)
      popwr_base_nxt = popwr_base_nxt + `WRAP_TARGET_HI;
    popwr_addr_nxt = popwr_base_nxt + idx_r;
    wrap_fault_nxt = (SIZED_SEL != 0) && wrap &&
                     (real_mode_in || seg_limit_in <= `SEG64K_LIMIT);
  end

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r           <= ST_IDLE;
      op_r              <= `OP_IDLE;
      op32_r            <= 1'b0;
      stack32_r         <= 1'b0;
      sp_saved_r        <= 32'h0;
      ip_r              <= 32'h0;
      idx_r             <= 32'h0;
      data_r            <= 32'h0;
      ip_phase_r        <= 1'b0;
      busy_out          <= 1'b0;
      done_out          <= 1'b0;
      fault_out         <= `FLT_NONE;
      stack_pointer_out <= 32'h0;
      rdata_out         <= 32'h0;
      mem_req_out       <= 1'b0;
      mem_we_out        <= 1'b0;
      mem_addr_out      <= 32'h0;
      mem_be_out        <= 4'h0;
      mem_wdata_out     <= 32'h0;
    end else begin
      done_out <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (req_valid_in) begin
            op_r              <= req_op_in;
            op32_r            <= op32_in | (req_op_in == `OP_PUSH_ERR);
            stack32_r         <= stack32_in;
            sp_saved_r        <= sp_init_in;
            stack_pointer_out <= sp_init_in;
            ip_r              <= call_ip_in;
            idx_r             <= index_disp_in;
            ip_phase_r        <= 1'b0;
            data_r            <= (req_op_in == `OP_PUSH_ERR) ?
                                 {16'h0, wdata_in[15:0]} : wdata_in;
            fault_out         <= `FLT_NONE;
            busy_out          <= 1'b1;
            if (req_op_in == `OP_FAR_CALL &&
                (branch_limit_err_in || branch_rights_err_in)) begin
              fault_out <= `FLT_BRANCH;
              state_r   <= ST_DONE;
            end else begin
              if (req_op_in == `OP_FAR_CALL)
                data_r <= {16'h0, call_cs_in};
              state_r <= ST_MEM;
            end
          end
        end
        ST_MEM: begin
          if (!mem_req_out) begin
            if (limit_hi_bad) begin
              fault_out <= `FLT_STACK;
              state_r   <= ST_DONE;
            end else begin
              mem_req_out <= 1'b1;
              mem_we_out  <= ~is_pop;
              mem_addr_out  <= acc_addr_nxt;
              mem_be_out    <= acc_be_nxt;
              mem_wdata_out <= acc_wdata_nxt;
              if (!is_pop)
                stack_pointer_out <= sp_dec;
            end
          end else if (mem_ready_in) begin
            mem_req_out <= 1'b0;
            if (mem_err_in) begin
              fault_out         <= `FLT_MEM;
              stack_pointer_out <= sp_saved_r;
              state_r           <= ST_DONE;
            end else if (is_pop) begin
              rdata_out <= pop_val_nxt;
              stack_pointer_out <= sp_inc;
              state_r <= after_acc_nxt;
              data_r  <= mem_rdata_in;
              if (op_r == `OP_POP_MEM && wrap_fault_nxt) begin
                fault_out         <= `FLT_STACK;
                stack_pointer_out <= sp_saved_r;
                state_r           <= ST_DONE;
              end
            end else if (op_r == `OP_FAR_CALL && !ip_phase_r) begin
              // old code segment first, pointer sized by operand below it
              data_r     <= ip_r;
              ip_phase_r <= 1'b1;
              state_r    <= after_acc_nxt;
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_PUSH2: begin
          // idle cycle lets the pointer settle before the second push
          state_r <= ST_MEM;
        end
        ST_POPWR: begin
          if (!mem_req_out) begin
            mem_req_out  <= 1'b1;
            mem_we_out   <= 1'b1;
            mem_be_out   <= op32_r ? `BE_ALL4 : `BE_LOW2;
            mem_wdata_out <= data_r;
            mem_addr_out  <= popwr_addr_nxt;
          end else if (mem_ready_in) begin
            mem_req_out <= 1'b0;
            if (mem_err_in) begin
              fault_out         <= `FLT_MEM;
              stack_pointer_out <= sp_saved_r;
            end
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // stack_push_pop_unit

// [verif/stack_unit_asserts.sv]
// port checker of the stack push/pop unit
`timescale 1ns/1ps
`include "stack_unit_map.vh"
module stack_unit_asserts #(parameter SIZED_SEL = 0) (
  input wire        core_clk_in, sys_rst_in, req_valid_in, op32_in,
  input wire        stack32_in, branch_limit_err_in, branch_rights_err_in,
  input wire        busy_out, done_out, mem_req_out, mem_we_out,
  input wire [2:0]  req_op_in, fault_out,
  input wire [3:0]  mem_be_out,
  input wire [31:0] sp_init_in, index_disp_in, stack_pointer_out,
  input wire [31:0] mem_addr_out, mem_wdata_out);
  reg  [68:0] q_r;
  wire [2:0]  op = q_r[68:66];
  wire [31:0] sp0 = q_r[63:32];
  wire        take = req_valid_in && !busy_out;
  wire        sel0 = SIZED_SEL == 0 && mem_req_out;
  wire        wrap = !q_r[64] &&
    sp0 == (q_r[65] ? `WRAP_SP_32 : `WRAP_SP_16);
  always @(posedge core_clk_in or posedge sys_rst_in)
    if (sys_rst_in) q_r <= 69'h0;
    else if (take) q_r <= {req_op_in, op32_in, stack32_in, sp_init_in,
      index_disp_in};
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_bad_call;
    take && req_op_in == `OP_FAR_CALL &&
      (branch_limit_err_in || branch_rights_err_in);
  endsequence
  AST_PUSH_BE: assert property (
    sel0 && op == `OP_PUSH_SEL |-> mem_be_out == `BE_LOW2)
    else $error("push width");
  AST_PUSH_AD: assert property (
    $rose(mem_req_out) && op == `OP_PUSH_SEL |->
      mem_addr_out == sp0 - (q_r[65] ? 32'h4 : 32'h2)) else $error("addr");
  AST_POP_BE: assert property (
    sel0 && op == `OP_POP_SEL |-> mem_be_out == `BE_LOW2 && !mem_we_out)
    else $error("pop width");
  AST_ERR: assert property (
    mem_req_out && op == `OP_PUSH_ERR && q_r[64] |-> mem_be_out ==
      `BE_ALL4 && mem_wdata_out[31:16] == 16'h0) else $error("err push");
  AST_WRAP: assert property (
    sel0 && op == `OP_POP_MEM && wrap && mem_we_out |->
      mem_addr_out == q_r[31:0]) else $error("wrap addr");
  AST_BR_FIRST: assert property (
    s_bad_call |=> (!mem_req_out throughout (##[0:3] done_out)))
    else $error("push before branch");
  AST_BR_CODE: assert property (
    s_bad_call |-> ##[1:4] (done_out && fault_out == `FLT_BRANCH))
    else $error("branch code");
  AST_RESTORE: assert property (
    done_out && fault_out != `FLT_NONE && op != `OP_POP_SEL &&
      op != `OP_POP_MEM |-> stack_pointer_out == sp0) else $error("sp");
endmodule // stack_unit_asserts

// [verif/stack_mem_model.sv]
// behavioural stack memory model
`timescale 1ns/1ps
module stack_mem_model (
  input  wire        clk_in, rst_in, req_in, err_en_in, slow_in,
  input  wire [31:0] addr_in, wdata_in,
  input  wire [3:0]  be_in,
  output reg         ready_out, err_out,
  output reg  [31:0] rdata_out,
  output reg  [67:0] log_out,
  output reg  [7:0]  n_acc_out);
  reg [2:0] cnt_r;
  always @(posedge clk_in or posedge rst_in)
    if (rst_in) begin
      {cnt_r, ready_out, err_out, rdata_out, log_out, n_acc_out} <= 113'h0;
    end else if (ready_out) begin
      ready_out <= 1'b0;
      err_out <= 1'b0;
      rdata_out <= ~rdata_out;
    end else if (req_in && cnt_r == (slow_in ? 3'h4 : 3'h1)) begin
      ready_out <= 1'b1;
      err_out <= err_en_in;
      cnt_r <= 3'h0;
      rdata_out <= {~addr_in[15:0], addr_in[15:0]};
      log_out <= {be_in, addr_in, wdata_in};
      n_acc_out <= n_acc_out + 8'h1;
    end else begin
      // read data is junk outside the answer cycle
      cnt_r <= req_in ? cnt_r + 3'h1 : 3'h0;
      rdata_out <= ~rdata_out;
    end
endmodule // stack_mem_model

// [verif/stack_push_pop_unit_test.sv]
// self-checking bench of the stack push/pop unit
`timescale 1ns/1ps
`include "stack_unit_map.vh"
module stack_push_pop_unit_test;
  reg         core_clk_in = 1'h0, sys_rst_in = 1'h1, req_valid_in = 1'h0;
  reg         op32_in = 1'h0, stack32_in = 1'h0, real_mode_in = 1'h0;
  reg         branch_limit_err_in = 1'h0, branch_rights_err_in = 1'h0;
  reg         slow = 1'h0, ferr = 1'h0;
  reg  [2:0]  req_op_in = 3'h0;
  reg  [15:0] call_cs_in = 16'h0123;
  reg  [31:0] seg_limit_in = 32'hfffff, sp_init_in = 32'h0, wdata_in = 32'h0;
  reg  [31:0] index_disp_in = 32'h10, call_ip_in = 32'h89ab0000;
  wire        busy_out, done_out, mem_req_out, mem_we_out, mem_ready_in;
  wire        mem_err_in;
  wire [2:0]  fault_out;
  wire [3:0]  mem_be_out;
  wire [31:0] stack_pointer_out, rdata_out, mem_addr_out, mem_wdata_out;
  wire [31:0] mem_rdata_in;
  wire [67:0] lg;
  wire [7:0]  nacc;
  integer     n_errors = 0, n_checks = 0, cyc = 0;
  stack_push_pop_unit i_dut (.*);
  stack_mem_model i_mem (.clk_in(core_clk_in), .rst_in(sys_rst_in),
    .req_in(mem_req_out), .err_en_in(ferr), .slow_in(slow),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .be_in(mem_be_out),
    .ready_out(mem_ready_in), .err_out(mem_err_in),
    .rdata_out(mem_rdata_in), .log_out(lg), .n_acc_out(nacc));
  initial forever #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      end_of_test;
    end
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      n_errors = n_errors + 1;
    end
  endtask
  task run(input [2:0] c, input w, input s, input [31:0] sp, d);
    integer k;
    @(posedge core_clk_in);
    {req_op_in, op32_in, stack32_in, sp_init_in} <= {c, w, s, sp};
    wdata_in <= d;
    req_valid_in <= 1'b1;
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    #1;
    for (k = 0; k < 60 && done_out !== 1'b1; k = k + 1)
      @(posedge core_clk_in) #1;
    chk("done", 32'h1, {31'h0, done_out});
  endtask
  task t_push;
    integer w;
    for (w = 0; w < 2; w = w + 1) begin
      run(`OP_PUSH_SEL, w[0], 1'b1, 32'h100, 32'habcd1234);
      chk("be", `BE_LOW2, lg[67:64]);
      chk("sp", w ? 32'hfc : 32'hfe, lg[63:32]);
      chk("sp", w ? 32'hfc : 32'hfe, stack_pointer_out);
      chk("sel", 32'h1234, lg[15:0]);
    end
  endtask
  task t_pop;
    run(`OP_POP_SEL, 1'b1, 1'b1, 32'h200, 32'h0);
    chk("be", `BE_LOW2, lg[67:64]);
    chk("sp", 32'h204, stack_pointer_out);
    chk("rdata", 32'h200, rdata_out);
  endtask
  task t_err;
    slow <= 1'b1;
    run(`OP_PUSH_ERR, 1'b0, 1'b1, 32'h400, 32'hdead0055);
    chk("code", 32'h55, lg[31:0]);
    chk("be", `BE_ALL4, lg[67:64]);
    chk("sp", 32'h3fc, stack_pointer_out);
    slow <= 1'b0;
  endtask
  task t_call;
    integer i;
    integer n0;
    for (i = 0; i < 3; i = i + 1) begin
      {branch_limit_err_in, branch_rights_err_in} <= i == 2 ? 2'h0 : i + 1;
      n0 = nacc;
      run(`OP_FAR_CALL, 1'b1, 1'b1, 32'h500, 32'h0);
      chk("fault", i == 2 ? `FLT_NONE : `FLT_BRANCH, fault_out);
      chk("count", i == 2 ? 32'h2 : 32'h0, nacc - n0);
    end
    chk("ip", 32'h89ab0000, lg[31:0]);
    chk("addr", 32'h4f8, lg[63:32]);
  endtask
  task t_wrap;
    integer w;
    for (w = 0; w < 2; w = w + 1) begin
      run(`OP_POP_MEM, w[0], 1'b0, w ? 32'hfffc : 32'hfffe, 32'h0);
      chk("addr", 32'h10, lg[63:32]);
      chk("data", w ? 32'hfffc : 32'hfffe, lg[15:0]);
    end
  endtask
  task t_fault;
    ferr <= 1'b1;
    run(`OP_PUSH_SEL, 1'b1, 1'b1, 32'h800, 32'h5);
    chk("fault", `FLT_MEM, fault_out);
    chk("sp", 32'h800, stack_pointer_out);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    t_push;
    t_pop;
    t_err;
    t_wrap;
    t_fault;
    @(posedge core_clk_in) ferr <= 1'b0;
    t_call;
    end_of_test;
  end
endmodule // stack_push_pop_unit_test
bind stack_push_pop_unit stack_unit_asserts #(.SIZED_SEL(SIZED_SEL)) i_chk (.*);
